//--- design/shift_defines.svh
`ifndef SHIFT_DEFINES_SVH
`define SHIFT_DEFINES_SVH

// Number of shift stages and storage bits
`define SR_STAGES 8
// Address width of the crossing buffer (depth is 2**AW)
`define SR_FIFO_AW 2
// Reset value of shift stages, storage register, skid buffer and shadow copy
`define SR_CLEAR_VALUE 8'h00
// Flops in each synchroniser chain
`define SR_SYNC_STAGES 2
// Entries of the skid buffer in front of the shadow copy
`define SR_SKID_DEPTH 2

`endif

//--- design/shift_pkg.sv
`include "shift_defines.svh"

package shift_pkg;

    // One word of shift stages or storage bits, bit n is stage n
    typedef struct packed {
        logic [`SR_STAGES-1:0] bits;
    } stage_word_t;

endpackage

//--- design/word_mem.sv
`timescale 1ns/1ns

// -----------------------------------------------------------------
// Dual-clock word memory, registered read port
// -----------------------------------------------------------------
module word_mem #(
    parameter int AW = 2
) (
    input wire logic wr_clock,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input shift_pkg::stage_word_t wr_data,
    input wire logic rd_clock,
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output shift_pkg::stage_word_t rd_data
);
    import shift_pkg::*;

    stage_word_t mem_q [0:(1<<AW)-1];

    always_ff @(posedge wr_clock) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge rd_clock) begin
        if (rd_en) begin
            rd_data <= mem_q[rd_addr];
        end
    end

endmodule // word_mem

//--- design/serial_in_shift_storage_register.sv
`timescale 1ns/1ns
`include "shift_defines.svh"

// Summary of operation
// RULE1: Eight-stage shift register plus separate eight-bit storage register driving outputs.
// RULE2: Each shift_clock rise with shift clear released shifts and captures serial_in.
// RULE3: Each storage_clock rise with storage clear released copies all stages.
// RULE4: Shift clear low zeroes stages and serial_out; storage stays unchanged.
// RULE5: Storage clear low zeroes storage and parallel outputs; stages unchanged.
// RULE6: Storage clock rising during shift clear loads zeros into storage.
// RULE7: Shift puts serial_in into stage 0; old stage 6 reaches serial_out.
// RULE8: Final stage drives serial_out so devices can be chained.
// RULE9: Storage load updates parallel outputs and leaves serial_out alone.
// RULE10: Clocks rising together: storage takes pre-edge shift contents, lagging one clock.
// RULE11: Each clear is level sensitive, active low, empties only its own register.
// RULE12: Controller sets serial_in before shifting, eight shifts, then storage clock. The testbench also sends words of 1 to 8 shifts before the storage clock.
// RULE13: Clears act without a clock and override simultaneous clock edges.
module serial_in_shift_storage_register #(
    parameter int STAGES = `SR_STAGES,
    parameter int FIFO_AW = `SR_FIFO_AW
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic shift_clock,
    input wire logic shift_clear_n,
    input wire logic storage_clock,
    input wire logic storage_clear_n,
    input wire logic serial_in,
    output logic serial_out,
    output shift_pkg::stage_word_t parallel_out
);
    import shift_pkg::*;

    if (STAGES != $bits(stage_word_t) || STAGES < 2 || FIFO_AW < 2) begin : g_bad_params
        $error("Unsupported STAGES or FIFO_AW value");
    end

    function automatic logic [FIFO_AW:0] bin2gray(input logic [FIFO_AW:0] b);
        bin2gray = b ^ (b >> 1);
    endfunction

    // -----------------------------------------------------------------
    // Shift stages (shift_clock domain)
    // -----------------------------------------------------------------
    // RULE1 stages and storage
    stage_word_t stage_q;
    stage_word_t stage_d;
    logic [STAGES-2:0] low_stages;
    logic penultimate_stage_bit;

    always_comb begin
        // RULE7 stage 0 entry
        stage_d.bits = {stage_q.bits[STAGES-2:0], serial_in};
        low_stages = stage_q.bits[STAGES-2:0];
        penultimate_stage_bit = stage_q.bits[STAGES-2];
    end

    // RULE13 async shift clear
    always_ff @(posedge shift_clock or negedge shift_clear_n) begin
        if (!shift_clear_n) begin
            // RULE4 stages zeroed
            stage_q <= `SR_CLEAR_VALUE;
            serial_out <= 1'b0;
        end else begin
            // RULE2 shift on edge
            stage_q <= stage_d;
            // RULE8 last stage out
            serial_out <= stage_d.bits[STAGES-1];
        end
    end

    // -----------------------------------------------------------------
    // Crossing buffer, write side (shift_clock domain)
    // -----------------------------------------------------------------
    logic wrst_s1_q;
    logic wrst_s2_q;
    logic [FIFO_AW:0] wptr_q;
    logic [FIFO_AW:0] wptr_d;
    logic [FIFO_AW:0] wgray_q;
    logic [FIFO_AW:0] wgray_d;
    logic [FIFO_AW:0] rg_s1_q;
    logic [FIFO_AW:0] rg_s2_q;
    logic [FIFO_AW:0] rptr_q;
    logic [FIFO_AW:0] rptr_d;
    logic [FIFO_AW:0] rgray_q;
    logic [FIFO_AW:0] rgray_d;
    logic wr_full;
    logic wr_en;

    always_comb begin
        wr_full = wgray_q == {~rg_s2_q[FIFO_AW:FIFO_AW-1], rg_s2_q[FIFO_AW-2:0]};
        wr_en = wrst_s2_q && !wr_full;
        wptr_d = wr_en ? wptr_q + 1'b1 : wptr_q;
        wgray_d = bin2gray(wptr_d);
    end

    always_ff @(posedge shift_clock) begin
        wrst_s1_q <= rst_b;
        wrst_s2_q <= wrst_s1_q;
        rg_s1_q <= rgray_q;
        rg_s2_q <= rg_s1_q;
        if (!wrst_s2_q) begin
            wptr_q <= '0;
            wgray_q <= '0;
        end else begin
            wptr_q <= wptr_d;
            wgray_q <= wgray_d;
        end
    end

    // -----------------------------------------------------------------
    // Crossing memory
    // -----------------------------------------------------------------
    logic rd_en;
    stage_word_t rd_data;

    word_mem #(
        .AW(FIFO_AW)
    ) u_word_mem (
        .wr_clock(shift_clock),
        .wr_en(wr_en),
        .wr_addr(wptr_q[FIFO_AW-1:0]),
        .wr_data(stage_d),
        .rd_clock(clock),
        .rd_en(rd_en),
        .rd_addr(rptr_q[FIFO_AW-1:0]),
        .rd_data(rd_data)
    );

    // -----------------------------------------------------------------
    // Pin and write pointer synchronisers (clock domain)
    // -----------------------------------------------------------------
    logic stc_s1_q;
    logic stc_s2_q;
    logic stc_s3_q;
    logic shc_s1_q;
    logic shc_s2_q;
    logic [FIFO_AW:0] wg_s1_q;
    logic [FIFO_AW:0] wg_s2_q;
    logic load_edge;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            stc_s1_q <= 1'b0;
            stc_s2_q <= 1'b0;
            stc_s3_q <= 1'b0;
            shc_s1_q <= 1'b0;
            shc_s2_q <= 1'b0;
            wg_s1_q <= '0;
            wg_s2_q <= '0;
        end else begin
            stc_s1_q <= storage_clock;
            stc_s2_q <= stc_s1_q;
            stc_s3_q <= stc_s2_q;
            shc_s1_q <= shift_clear_n;
            shc_s2_q <= shc_s1_q;
            wg_s1_q <= wgray_q;
            wg_s2_q <= wg_s1_q;
        end
    end

    // -----------------------------------------------------------------
    // Read side and skid buffer (clock domain)
    // -----------------------------------------------------------------
    logic pend_q;
    logic pend_d;
    stage_word_t skid_q [0:`SR_SKID_DEPTH-1];
    stage_word_t skid_d [0:`SR_SKID_DEPTH-1];
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic rd_empty;
    logic in_ready;
    logic out_valid;
    logic out_ready;
    logic push;
    logic pop;
    stage_word_t shadow_q;
    stage_word_t shadow_d;

    always_comb begin
        load_edge = stc_s2_q && !stc_s3_q;
        rd_empty = rgray_q == wg_s2_q;
        in_ready = ({1'b0, cnt_q} + {2'b00, pend_q}) < 3'd2;
        rd_en = !rd_empty && in_ready;
        rptr_d = rd_en ? rptr_q + 1'b1 : rptr_q;
        rgray_d = bin2gray(rptr_d);
        pend_d = rd_en;
        push = pend_q;
        out_valid = cnt_q != 2'd0;
        // Hold the shadow still in the cycle it is stored
        out_ready = !load_edge;
        pop = out_valid && out_ready;
        skid_d[0] = skid_q[0];
        skid_d[1] = skid_q[1];
        cnt_d = cnt_q;
        case ({push, pop})
            2'b10: begin
                skid_d[cnt_q[0]] = rd_data;
                cnt_d = cnt_q + 2'd1;
            end
            2'b01: begin
                skid_d[0] = skid_q[1];
                cnt_d = cnt_q - 2'd1;
            end
            2'b11: begin
                if (cnt_q == 2'd1) begin
                    skid_d[0] = rd_data;
                end else begin
                    skid_d[0] = skid_q[1];
                    skid_d[1] = rd_data;
                end
            end
            default: begin
                cnt_d = cnt_q;
            end
        endcase
        // RULE4 shadow follows clear
        if (!shc_s2_q) begin
            shadow_d = `SR_CLEAR_VALUE;
        end else if (pop) begin
            shadow_d = skid_q[0];
        end else begin
            shadow_d = shadow_q;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rptr_q <= '0;
            rgray_q <= '0;
            pend_q <= 1'b0;
            cnt_q <= 2'd0;
            skid_q[0] <= `SR_CLEAR_VALUE;
            skid_q[1] <= `SR_CLEAR_VALUE;
            shadow_q <= `SR_CLEAR_VALUE;
        end else begin
            rptr_q <= rptr_d;
            rgray_q <= rgray_d;
            pend_q <= pend_d;
            cnt_q <= cnt_d;
            skid_q[0] <= skid_d[0];
            skid_q[1] <= skid_d[1];
            shadow_q <= shadow_d;
        end
    end

    // -----------------------------------------------------------------
    // Storage register
    // -----------------------------------------------------------------
    // RULE9 serial_out untouched
    stage_word_t parallel_d;

    always_comb begin
        parallel_d = parallel_out;
        if (load_edge) begin
            // RULE6 cleared stages load
            if (!shc_s2_q) begin
                parallel_d = `SR_CLEAR_VALUE;
            end else begin
                // RULE10 pre-edge contents
                parallel_d = shadow_q;
            end
        end
    end

    // RULE13 async storage clear
    // RULE11 own register only
    always_ff @(posedge clock or negedge storage_clear_n) begin
        if (!storage_clear_n) begin
            // RULE5 outputs zeroed
            parallel_out <= `SR_CLEAR_VALUE;
        end else if (!rst_b) begin
            parallel_out <= `SR_CLEAR_VALUE;
        end else begin
            // RULE3 copy stages
            parallel_out <= parallel_d;
        end
    end

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    property p_shift_move;
        @(posedge shift_clock) disable iff (!shift_clear_n)
        stage_q.bits[STAGES-1:1] == $past(low_stages);
    endproperty
    a_shift_move: assert property (p_shift_move) // RULE2
        else $error("shift stages did not move");

    // Previous edge must have shifted, not been held in clear
    property p_serial_tail;
        @(posedge shift_clock) disable iff (!shift_clear_n)
        $past(shift_clear_n) |->
            serial_out == $past(penultimate_stage_bit) && stage_q.bits[0] == $past(serial_in);
    endproperty
    a_serial_tail: assert property (p_serial_tail) // RULE7
        else $error("serial tail wrong");

    property p_serial_last;
        @(posedge clock) disable iff (!rst_b)
        serial_out == stage_q.bits[STAGES-1];
    endproperty
    a_serial_last: assert property (p_serial_last) // RULE8
        else $error("serial_out not last stage");

    property p_shadow_clear;
        @(posedge clock) disable iff (!rst_b)
        !shc_s2_q ##1 !shc_s2_q |-> shadow_q == `SR_CLEAR_VALUE;
    endproperty
    a_shadow_clear: assert property (p_shadow_clear) // RULE4
        else $error("shadow not cleared");

    property p_clear_load;
        @(posedge clock) disable iff (!rst_b || !storage_clear_n)
        load_edge && !shc_s2_q |=> parallel_out == `SR_CLEAR_VALUE;
    endproperty
    a_clear_load: assert property (p_clear_load) // RULE6
        else $error("cleared stages not loaded");

    property p_store_copy;
        @(posedge clock) disable iff (!rst_b || !storage_clear_n)
        load_edge && shc_s2_q |=> parallel_out == $past(shadow_q);
    endproperty
    a_store_copy: assert property (p_store_copy) // RULE3
        else $error("storage did not copy stages");

    property p_store_clear;
        @(posedge clock) disable iff (!rst_b)
        !storage_clear_n |-> parallel_out == `SR_CLEAR_VALUE;
    endproperty
    a_store_clear: assert property (p_store_clear) // RULE5
        else $error("storage not cleared");

    property p_store_hold;
        @(posedge clock) disable iff (!rst_b || !storage_clear_n)
        !load_edge |=> $stable(parallel_out);
    endproperty
    a_store_hold: assert property (p_store_hold) // RULE11
        else $error("storage changed without edge");

    property p_skid_room;
        @(posedge clock) disable iff (!rst_b)
        ({1'b0, cnt_q} + {2'b00, pend_q}) <= 3'd2;
    endproperty
    a_skid_room: assert property (p_skid_room)
        else $error("skid buffer overrun");

endmodule // serial_in_shift_storage_register

//--- testbench/shift_link_model.sv
`timescale 1ns/1ns

// ---------------------------------------------------------------
// Controller on the far side of the shift link
// ---------------------------------------------------------------
module shift_link_model (
    output logic shift_clock,
    output logic serial_in
);
    // Link clock stands still outside frames
    initial begin
        shift_clock = 1'b0;
        serial_in = 1'b0;
    end

    task automatic send(input logic [7:0] word, input int nbits);
        #37;
        for (int i = nbits - 1; i >= 0; i--) begin
            serial_in = word[i];
            #80 shift_clock = 1'b1;
            #80 shift_clock = 1'b0;
        end
        // Data line no longer held, show a changed level
        serial_in = ~serial_in;
    endtask
endmodule // shift_link_model

//--- testbench/serial_in_shift_storage_register_tb_top.sv
`timescale 1ns/1ns

`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("[ERR] %0t got %h expected %h", $time, got, exp); end end

module serial_in_shift_storage_register_tb_top;
    import shift_pkg::*;

    logic clock, rst_b, shift_clock, shift_clear_n, storage_clock, storage_clear_n;
    logic serial_in, serial_out;
    stage_word_t parallel_out;
    int num_errors = 0;
    int checks = 0;
    logic [7:0] exp_shift = 8'h00;
    logic [7:0] exp_store = 8'h00;
    logic [7:0] prior;
    logic [31:0] seed = 32'h00017eb6;

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    serial_in_shift_storage_register serial_in_shift_storage_register_inst (
        .clock(clock),
        .rst_b(rst_b),
        .shift_clock(shift_clock),
        .shift_clear_n(shift_clear_n),
        .storage_clock(storage_clock),
        .storage_clear_n(storage_clear_n),
        .serial_in(serial_in),
        .serial_out(serial_out),
        .parallel_out(parallel_out)
    );

    shift_link_model shift_link_model_inst (
        .shift_clock(shift_clock),
        .serial_in(serial_in)
    );

    // ---------------------------------------------------------------
    // Helpers and reference model
    // ---------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic shift_word(input logic [7:0] w, input int n);
        shift_link_model_inst.send(w, n);
        for (int i = n - 1; i >= 0; i--)
            exp_shift = {exp_shift[6:0], w[i]};
        if (shift_clear_n !== 1'b1)
            exp_shift = 8'h00;
    endtask

    task automatic store_pulse();
        @(posedge clock);
        storage_clock <= 1'b1;
        tick(3);
        storage_clock <= 1'b0;
        if (storage_clear_n === 1'b1)
            exp_store = (shift_clear_n === 1'b1) ? exp_shift : 8'h00;
        tick(4);
    endtask

    task automatic conclude();
        $display("Counts: %0d checks, %0d errors", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        for (int t = 0; t < 60000; t++)
            @(posedge clock);
        num_errors++;
        $display("[ERR] %0t run exceeded its cycle bound", $time);
        conclude();
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        shift_clear_n = 1'b0;
        storage_clear_n = 1'b1;
        storage_clock = 1'b0;
        fork
            tick(16);
            shift_word(8'ha5, 8);
        join
        rst_b <= 1'b1;
        shift_word(8'hff, 8);
        `CHK(serial_out, 1'b0)
        `CHK(parallel_out.bits, 8'h00)
        $display("test reset done");
        tick(1);
        shift_clear_n <= 1'b1;
        tick(8);
        for (int k = 0; k < 8; k++) begin
            seed = lfsr_next(seed);
            shift_word(seed[7:0], 1 + int'(seed[10:8]));
            `CHK(serial_out, exp_shift[7])
            tick(8);
            store_pulse();
            `CHK(parallel_out.bits, exp_store)
            `CHK(serial_out, exp_shift[7])
        end
        $display("test words done");
        tick(1);
        storage_clear_n <= 1'b0;
        tick(2);
        `CHK(parallel_out.bits, 8'h00)
        `CHK(serial_out, exp_shift[7])
        storage_clear_n <= 1'b1;
        exp_store = 8'h00;
        tick(4);
        `CHK(parallel_out.bits, 8'h00)
        store_pulse();
        `CHK(parallel_out.bits, exp_store)
        $display("test storage clear done");
        shift_clear_n <= 1'b0;
        tick(2);
        `CHK(serial_out, 1'b0)
        `CHK(parallel_out.bits, exp_store)
        exp_shift = 8'h00;
        shift_word(8'h5a, 8);
        `CHK(serial_out, 1'b0)
        tick(8);
        store_pulse();
        `CHK(parallel_out.bits, 8'h00)
        tick(1);
        shift_clear_n <= 1'b1;
        tick(8);
        $display("test shift clear done");
        shift_word(8'hc3, 8);
        tick(8);
        store_pulse();
        `CHK(parallel_out.bits, 8'hc3)
        prior = exp_shift;
        fork
            shift_word(8'h01, 1);
            begin
                tick(1);
                storage_clock <= 1'b1;
                tick(3);
                storage_clock <= 1'b0;
                tick(4);
            end
        join
        `CHK(parallel_out.bits, prior)
        store_pulse();
        `CHK(parallel_out.bits, exp_store)
        $display("test joint clocks done");
        conclude();
    end
endmodule // serial_in_shift_storage_register_tb_top
